/* ssp_pkg.sv */
// shared constants of the serial shift port
package ssp_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, one aligned 32-bit word each)
  // ------------------------------------------------------------------
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_DATA     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ------------------------------------------------------------------
  // control_reg fields
  // ------------------------------------------------------------------
  localparam int         CTRL_W        = 7;
  localparam int         CTRL_SEL      = 0;  // serial_port_select
  localparam int         CTRL_RATE_LO  = 1;  // rate_select_lo
  localparam int         CTRL_RATE_HI  = 2;  // rate_select_hi
  localparam int         CTRL_MASTER   = 3;  // clock pin config: 1 drive internal clock
  localparam int         CTRL_SO_DRIVE = 4;  // output pin config: 1 drive serial out
  localparam int         CTRL_IDLE_HI  = 5;  // port_g_bit5 data: idle level of clock
  localparam int         CTRL_PHASE    = 6;  // clock_phase_select
  localparam logic [6:0] CTRL_RST      = 7'h00;

  // ------------------------------------------------------------------
  // processor_status_reg and interrupt fields
  // ------------------------------------------------------------------
  localparam int         STAT_BUSY     = 0;
  localparam int         STAT_CNT_LSB  = 4;
  localparam int         IRQ_DONE      = 0;
  localparam logic [7:0] DATA_RST      = 8'h00;

  // ------------------------------------------------------------------
  // transfer length and clock rate (times in instruction cycles = pclk)
  // ------------------------------------------------------------------
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [3:0] LAST_EDGE     = 4'hF;
  localparam int         PERIOD_TC_00  = 2;
  localparam int         PERIOD_TC_01  = 4;
  localparam int         PERIOD_TC_1X  = 8;
  localparam logic [2:0] HALF_00       = 3'(PERIOD_TC_00 / 2);
  localparam logic [2:0] HALF_01       = 3'(PERIOD_TC_01 / 2);
  localparam logic [2:0] HALF_1X       = 3'(PERIOD_TC_1X / 2);

endpackage : ssp_pkg

/* ssp_sync2.sv */
// two-flop synchroniser for one level from outside the pclk domain
`timescale 1ns/100ps
module ssp_sync2 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;
endmodule : ssp_sync2

/* ssp_rate_gen.sv */
// half-period tick generator for the master shift clock
`timescale 1ns/100ps
module ssp_rate_gen
  import ssp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic en,
  input  wire logic rate_lo,
  input  wire logic rate_hi,
  output logic      tick
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] half;

  always_comb begin
    if (rate_hi) begin
      half = HALF_1X;
    end else if (rate_lo) begin
      half = HALF_01;
    end else begin
      half = HALF_00;
    end
    tick  = en && (cnt_q == 3'(half - 3'h1));
    cnt_d = (!en || tick) ? 3'h0 : 3'(cnt_q + 3'h1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : ssp_rate_gen

/* ssp_top.sv */
// serial shift port: APB registers, shift engine, pin control
`timescale 1ns/100ps

module ssp_top
  import ssp_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ssp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sck_i,
  output logic                           sck_o,
  output logic                           sck_oe,
  input  wire logic                      sdi,
  output logic                           sdo,
  output logic                           sdo_oe,
  output logic                           irq
);
  import ssp_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q,    ctrl_d;
  logic [7:0]        sio_q,     sio_d;
  logic              busy_q,    busy_d;
  logic [2:0]        bitcnt_q,  bitcnt_d;
  logic [3:0]        edgecnt_q, edgecnt_d;
  logic              sck_q,     sck_d;
  logic              sdo_q,     sdo_d;
  logic              prev_q,    prev_d;
  logic              done_st_q, done_st_d;
  logic              mask_q,    mask_d;
  logic              irq_q,     irq_d;
  logic              fin_q,     fin_d;
  logic              sck_oe_q,  sck_oe_d;
  logic              sdo_oe_q,  sdo_oe_d;
  logic [31:0]       prdata_q,  prdata_d;
  logic              pready_q,  pready_d;
  logic              pslverr_q, pslverr_d;

  logic sck_s;
  logic sdi_s;
  logic tick;
  logic master;
  logic idle_lvl;
  logic samp_rise;
  logic samp_ev;
  logic out_ev;
  logic done_ev;
  logic acc_wr;
  logic rd_phase;
  logic mapped;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_istat;
  logic wr_mask;
  logic start;
  logic [31:0] rd_mux;

  // ------------------------------------------------------------------
  // pin inputs and master clock rate
  // ------------------------------------------------------------------
  ssp_sync2 u_sync_sck (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (sck_i),
    .q       (sck_s)
  );

  ssp_sync2 u_sync_sdi (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (sdi),
    .q       (sdi_s)
  );

  ssp_rate_gen u_rate (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (busy_q && master),
    .rate_lo (ctrl_q[CTRL_RATE_LO]),
    .rate_hi (ctrl_q[CTRL_RATE_HI]),
    .tick    (tick)
  );

  // ------------------------------------------------------------------
  // bus decode; one wait state so read data leaves a flop
  // ------------------------------------------------------------------
  always_comb begin
    mapped   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_DATA)
            || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);
    acc_wr   = psel && penable && pready_q && pwrite;
    rd_phase = psel && penable && !pready_q;
    wr_ctrl  = acc_wr && (paddr == ADDR_CTRL);
    wr_stat  = acc_wr && (paddr == ADDR_STATUS);
    wr_data  = acc_wr && (paddr == ADDR_DATA);
    wr_istat = acc_wr && (paddr == ADDR_IRQ_STAT);
    wr_mask  = acc_wr && (paddr == ADDR_IRQ_MASK);
    rd_mux   = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL:     rd_mux[CTRL_W-1:0] = ctrl_q;
      ADDR_STATUS: begin
        rd_mux[STAT_BUSY]                  = busy_q;
        rd_mux[STAT_CNT_LSB +: 3]          = bitcnt_q;
      end
      ADDR_DATA:     rd_mux[7:0]        = sio_q;
      ADDR_IRQ_STAT: rd_mux[IRQ_DONE]   = done_st_q;
      ADDR_IRQ_MASK: rd_mux[IRQ_DONE]   = mask_q;
      default:       rd_mux             = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // clock edges and shift events
  // ------------------------------------------------------------------
  always_comb begin
    // master on internal clock, slave on pin
    master    = ctrl_q[CTRL_MASTER];
    // idle level from data bit five
    idle_lvl  = ctrl_q[CTRL_IDLE_HI];
    // sample edge follows phase and idle level
    samp_rise = !(ctrl_q[CTRL_PHASE] ^ ctrl_q[CTRL_IDLE_HI]);
    if (master) begin
      // only the internal tick moves a master transfer
      samp_ev = busy_q && tick && (sck_q ^ samp_rise);
      out_ev  = busy_q && tick && !(sck_q ^ samp_rise);
    end else begin
      samp_ev = busy_q && (samp_rise ? (sck_s && !prev_q) : (!sck_s && prev_q));
      out_ev  = busy_q && (samp_rise ? (!sck_s && prev_q) : (sck_s && !prev_q));
    end
    // eight bits, or sixteen clock edges when master
    done_ev = master ? (busy_q && tick && (edgecnt_q == LAST_EDGE))
                     : (samp_ev && (bitcnt_q == LAST_BIT));
    start   = wr_stat && pwdata[STAT_BUSY] && !busy_q;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_d    = wr_ctrl ? pwdata[CTRL_W-1:0] : ctrl_q;
    mask_d    = wr_mask ? pwdata[IRQ_DONE] : mask_q;
    prev_d    = sck_s;
    sio_d     = sio_q;
    sdo_d     = sdo_q;
    bitcnt_d  = bitcnt_q;
    edgecnt_d = edgecnt_q;
    busy_d    = busy_q;
    sck_d     = sck_q;

    // software loads at any time, busy or idle; a load mid-shift wins
    if (wr_data) begin
      sio_d = pwdata[7:0];
      sdo_d = pwdata[7];
    end else if (samp_ev) begin
      // shift toward the top, new bit at the bottom
      sio_d = {sio_q[6:0], sdi_s};
    end
    // output changes on the opposite edge
    if (out_ev && !wr_data) begin
      sdo_d = sio_q[7];
    end

    if (samp_ev) begin
      bitcnt_d = 3'(bitcnt_q + 3'h1);
    end
    if (busy_q && master && tick) begin
      edgecnt_d = 4'(edgecnt_q + 4'h1);
      sck_d     = !sck_q;
    end
    if (!busy_q) begin
      // clock rests at idle level between transfers
      sck_d = idle_lvl;
    end

    // hardware clears busy after the eighth bit
    if (done_ev) begin
      busy_d = 1'b0;
    end
    // software write sets or aborts; the write wins
    if (wr_stat) begin
      busy_d = pwdata[STAT_BUSY];
    end
    if (start) begin
      // slave starts counting at the busy write
      bitcnt_d  = 3'h0;
      edgecnt_d = 4'h0;
      sdo_d     = wr_data ? pwdata[7] : sio_q[7];
    end

    // sticky completion flag, set beats write-one clear
    done_st_d = done_ev || (done_st_q && !(wr_istat && pwdata[IRQ_DONE]));
    fin_d     = done_ev;
    irq_d     = done_st_d && mask_d;

    sck_oe_d  = ctrl_q[CTRL_SEL] && ctrl_q[CTRL_MASTER];
    sdo_oe_d  = ctrl_q[CTRL_SEL] && ctrl_q[CTRL_SO_DRIVE];

    pready_d  = rd_phase;
    prdata_d  = (rd_phase && !pwrite) ? rd_mux : 32'h0000_0000;
    pslverr_d = rd_phase && !mapped;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // phase select and all control start cleared
      ctrl_q    <= CTRL_RST;
      sio_q     <= DATA_RST;
      busy_q    <= 1'b0;
      bitcnt_q  <= 3'h0;
      edgecnt_q <= 4'h0;
      sck_q     <= 1'b0;
      sdo_q     <= 1'b0;
      prev_q    <= 1'b0;
      done_st_q <= 1'b0;
      mask_q    <= 1'b0;
      irq_q     <= 1'b0;
      fin_q     <= 1'b0;
      sck_oe_q  <= 1'b0;
      sdo_oe_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      sio_q     <= sio_d;
      busy_q    <= busy_d;
      bitcnt_q  <= bitcnt_d;
      edgecnt_q <= edgecnt_d;
      sck_q     <= sck_d;
      sdo_q     <= sdo_d;
      prev_q    <= prev_d;
      done_st_q <= done_st_d;
      mask_q    <= mask_d;
      irq_q     <= irq_d;
      fin_q     <= fin_d;
      sck_oe_q  <= sck_oe_d;
      sdo_oe_q  <= sdo_oe_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign sck_o   = sck_q;
  assign sck_oe  = sck_oe_q;
  assign sdo     = sdo_q;
  assign sdo_oe  = sdo_oe_q;
  assign irq     = irq_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_busy_start;
    @(posedge pclk) disable iff (!presetn)
      (wr_stat && pwdata[STAT_BUSY]) |=> busy_q;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set by write");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
      (wr_stat && !pwdata[STAT_BUSY]) |=> (!busy_q && !fin_q);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop shifting");

  property p_slave_eight;
    @(posedge pclk) disable iff (!presetn)
      (fin_q && !master) |-> ($past(bitcnt_q) == LAST_BIT && !busy_q);
  endproperty
  a_slave_eight: assert property (p_slave_eight) else $error("slave ended off eight");

  property p_master_edges;
    @(posedge pclk) disable iff (!presetn)
      (fin_q && master) |-> ($past(edgecnt_q) == LAST_EDGE && sck_q == idle_lvl);
  endproperty
  a_master_edges: assert property (p_master_edges) else $error("clock not 8 pulses");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (fin_q && mask_q && !$past(wr_mask)) |-> ##[0:1] irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing on completion");

  property p_slow_rate;
    @(posedge pclk) disable iff (!presetn)
      (tick && ctrl_q[CTRL_RATE_HI] && !wr_ctrl) |=> !tick [*3];
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("eight cycle period broken");

  property p_pin_select;
    @(posedge pclk) disable iff (!presetn)
      (sck_oe_q || sdo_oe_q) |-> $past(ctrl_q[CTRL_SEL]);
  endproperty
  a_pin_select: assert property (p_pin_select) else $error("pin driven unselected");

  property p_shift_msb;
    @(posedge pclk) disable iff (!presetn)
      (samp_ev && !wr_data) |=> (sio_q == {$past(sio_q[6:0]), $past(sdi_s)});
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("shift order wrong");

  c_master_done: cover property (@(posedge pclk) disable iff (!presetn) fin_q && master);
  c_slave_done:  cover property (@(posedge pclk) disable iff (!presetn) fin_q && !master);
  c_abort:       cover property (@(posedge pclk) disable iff (!presetn)
                                 busy_q && wr_stat && !pwdata[STAT_BUSY]);
  c_irq:         cover property (@(posedge pclk) disable iff (!presetn) irq_q);

endmodule : ssp_top

/* ssp_far_end.sv */
// far-end peripheral model facing the serial shift port pins
`timescale 1ns/100ps
module ssp_far_end (
  input  wire logic sck_line,
  input  wire logic sdo_line,
  input  wire logic idle_hi,
  input  wire logic alt_phase,
  output logic      sdi,
  output logic      sck_drv
);
  logic [7:0] tx_sh;
  logic [7:0] rx_q;
  logic       seen_smp;
  logic       smp_rise;

  // sample edge follows phase and idle level
  assign smp_rise = (alt_phase == idle_hi);
  assign sdi      = tx_sh[7];

  initial begin
    tx_sh    = 8'h00;
    rx_q     = 8'h00;
    seen_smp = 1'b0;
    sck_drv  = 1'b0;
  end

  // ------------------------------------------------------------
  // shifting on the wire clock
  // ------------------------------------------------------------
  task automatic take_bit;
    rx_q     = {rx_q[6:0], sdo_line};
    seen_smp = 1'b1;
  endtask : take_bit

  // no shift before the first sample, so bit 7 survives a leading output edge;
  // vacated bits toggle so stale data is never mistaken for a good bit
  task automatic put_bit;
    if (seen_smp) begin
      tx_sh = {tx_sh[6:0], ~tx_sh[0]};
    end
  endtask : put_bit

  always @(posedge sck_line) begin
    if (smp_rise) take_bit(); else put_bit();
  end

  always @(negedge sck_line) begin
    if (smp_rise) put_bit(); else take_bit();
  end

  task automatic load(input logic [7:0] b);
    tx_sh    = b;
    rx_q     = 8'h00;
    seen_smp = 1'b0;
    sck_drv  = idle_hi;
  endtask : load

  // clock only driven here, for slave frames; stands at idle otherwise
  task automatic drive_frame(input int nbits);
    // keep wire clock edges clear of the sampling clock edges
    #10;
    repeat (nbits) begin
      #200;
      sck_drv = ~sck_drv;
      #200;
      sck_drv = ~sck_drv;
    end
  endtask : drive_frame
endmodule : ssp_far_end

/* ssp_top_tb.sv */
// self-checking bench for the serial shift port
`timescale 1ns/100ps
module ssp_top_tb;
  import ssp_pkg::*;
  localparam int MAX_CYC = 20000;
  localparam logic [6:0] MCTL [7] = '{7'h19, 7'h1B, 7'h1D, 7'h1F, 7'h5D, 7'h3D, 7'h7D};
  localparam int MPER [7] = '{PERIOD_TC_00*50, PERIOD_TC_01*50, PERIOD_TC_1X*50,
                              PERIOD_TC_1X*50, PERIOD_TC_1X*50, PERIOD_TC_1X*50, PERIOD_TC_1X*50};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sck_o;
  logic        sck_oe;
  logic        sdo;
  logic        sdo_oe;
  logic        irq;
  logic        sdi;
  logic        far_sck;
  logic        sck_line;
  logic        sdo_line;
  logic        cfg_idle;
  logic        cfg_alt;
  logic [31:0] rd;
  logic        err_q;
  logic [7:0]  dev_b;
  int          fails;
  int          n_tests;
  int          n_pulse;
  int          cycles;
  int          k;
  realtime     t_last;
  realtime     per;

  // released data line shows the inverse of its last level
  assign sck_line = sck_oe ? sck_o : far_sck;
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  ssp_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_i(sck_line), .sck_o(sck_o), .sck_oe(sck_oe), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .irq(irq));

  ssp_far_end far (.sck_line(sck_line), .sdo_line(sdo_line), .idle_hi(cfg_idle),
    .alt_phase(cfg_alt), .sdi(sdi), .sck_drv(far_sck));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge sck_line) begin
    if (sck_oe) begin
      n_pulse++;
      per    = $realtime - t_last;
      t_last = $realtime;
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      fails++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // access and check tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // ends on pready; with no limit of its own, only the bench timeout ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd    = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 300);
  endtask : wait_idle

  task close_out;
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, presetn, cfg_idle, cfg_alt} = 6'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    fails   = 0;
    n_tests = 0;
    n_pulse = 0;
    cycles  = 0;
    t_last  = 0;
    per     = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'(CTRL_RST));
    chk("pins off", 32'({sck_oe, sdo_oe}), 32'h0);
    apb(1'b1, 8'hFC, 32'hFFFFFFFF);
    chk("unmapped err", 32'(err_q), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      cfg_idle = MCTL[i][CTRL_IDLE_HI];
      cfg_alt  = MCTL[i][CTRL_PHASE];
      dev_b    = 8'hA5 ^ 8'(i);
      apb(1'b1, ADDR_CTRL, 32'(MCTL[i]));
      apb(1'b1, ADDR_IRQ_MASK, 32'(i % 2));
      apb(1'b1, ADDR_DATA, 32'(dev_b));
      chk("idle level", 32'(sck_o), 32'(cfg_idle));
      chk("master pins", 32'({sck_oe, sdo_oe}), 32'h3);
      far.load(8'h3C + 8'(i));
      n_pulse = 0;
      apb(1'b1, ADDR_STATUS, 32'h1);
      wait_idle();
      chk("busy clear", 32'(rd[STAT_BUSY]), 32'h0);
      chk("pulses", 32'(n_pulse), 32'h8);
      chk("period", 32'(int'(per)), 32'(MPER[i]));
      chk("far rx", 32'(far.rx_q), 32'(dev_b));
      // slow rates only: fast rates outrun the input synchroniser
      if (MCTL[i][CTRL_RATE_HI]) begin
        apb(1'b0, ADDR_DATA, 32'h0);
        chk("dev rx", rd, 32'(8'h3C + 8'(i)));
      end
      chk("irq", 32'(irq), 32'(i % 2));
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("done stat", rd, 32'h1);
      apb(1'b1, ADDR_IRQ_STAT, 32'h1);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("done clr", rd, 32'h0);
      chk("irq clr", 32'(irq), 32'h0);
    end
    $display("test master done");
    cfg_idle = 1'b0;
    cfg_alt  = 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h1D);
    apb(1'b1, ADDR_DATA, 32'hC3);
    far.load(8'h81);
    n_pulse = 0;
    apb(1'b1, ADDR_STATUS, 32'h1);
    for (k = 0; k < 400 && n_pulse < 3; k++) @(posedge pclk);
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("abort busy", 32'(rd[STAT_BUSY]), 32'h0);
    k = n_pulse;
    repeat (100) @(posedge pclk);
    chk("abort stop", 32'(n_pulse), 32'(k));
    chk("abort short", 32'(n_pulse < 8), 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("abort no done", rd, 32'h0);
    $display("test abort done");
    apb(1'b1, ADDR_CTRL, 32'h11);
    apb(1'b1, ADDR_DATA, 32'h96);
    far.load(8'h5A);
    // busy set at once, with the incoming clock idle
    apb(1'b1, ADDR_STATUS, 32'h1);
    chk("slave pins", 32'({sck_oe, sdo_oe}), 32'h1);
    far.drive_frame(8);
    repeat (10) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("slave busy", 32'(rd[STAT_BUSY]), 32'h0);
    apb(1'b0, ADDR_DATA, 32'h0);
    chk("slave rx", rd, 32'h5A);
    chk("slave far rx", 32'(far.rx_q), 32'h96);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("slave done", rd, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h01);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("so tristate", 32'(sdo_oe), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h18);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("deselect", 32'({sck_oe, sdo_oe}), 32'h0);
    $display("test slave done");
    close_out();
  end
endmodule : ssp_top_tb
